/* File: hdl/flash_param_pkg.sv */
`default_nettype none
package flash_param_pkg;
    // own apb registers, indices (byte address is four times the index)
    localparam logic [9:0]  IDX_CONTROL   = 10'h000;
    localparam logic [9:0]  IDX_STATUS    = 10'h001;
    localparam logic [0:0]  CONTROL_RESET = 1'h1;
    // parameter table offsets, also the apb indices
    localparam logic [23:0] OFS_QUAD_MODE_SWITCH = 24'h000068;
    localparam logic [23:0] OFS_CONT_READ_EXIT   = 24'h000069;
    localparam logic [23:0] OFS_QUAD_ENABLE_LOC  = 24'h00006A;
    localparam logic [23:0] OFS_WORD15_RESERVED  = 24'h00006B;
    localparam logic [23:0] OFS_STATUS_WREN      = 24'h00006C;
    localparam logic [23:0] OFS_SOFT_RESET       = 24'h00006D;
    localparam logic [23:0] OFS_WIDE_ADDR_EXIT   = 24'h00006E;
    localparam logic [23:0] OFS_WIDE_ADDR_ENTRY  = 24'h00006F;
    localparam logic [23:0] OFS_MAP_HEADER       = 24'h000100;
    localparam logic [23:0] OFS_MAP_CONFIG_ID    = 24'h000101;
    localparam logic [23:0] OFS_MAP_REGION_COUNT = 24'h000102;
    // parameter table contents
    localparam logic [7:0]  VAL_QUAD_MODE_SWITCH = 8'h29;
    localparam logic [7:0]  VAL_CONT_READ_EXIT   = 8'hC2;
    localparam logic [7:0]  VAL_QUAD_ENABLE_LOC  = 8'h5C;
    localparam logic [7:0]  VAL_WORD15_RESERVED  = 8'hFF;
    localparam logic [7:0]  VAL_STATUS_WREN      = 8'hF0;
    localparam logic [7:0]  VAL_SOFT_RESET       = 8'h30;
    localparam logic [7:0]  VAL_WIDE_ADDR_EXIT   = 8'hC0;
    localparam logic [7:0]  VAL_WIDE_ADDR_ENTRY  = 8'h80;
    localparam logic [7:0]  VAL_MAP_HEADER       = 8'hFF;
    localparam logic [7:0]  VAL_MAP_CONFIG_ID    = 8'h00;
    localparam logic [7:0]  VAL_MAP_REGION_COUNT = 8'h04;
    localparam logic [7:0]  VAL_UNUSED           = 8'hFF;
    // link instructions
    localparam logic [7:0]  OP_QUAD_ENTER    = 8'h38;
    localparam logic [7:0]  OP_QUAD_EXIT     = 8'hFF;
    localparam logic [7:0]  OP_RESET_ENABLE  = 8'h66;
    localparam logic [7:0]  OP_RESET         = 8'h99;
    localparam logic [7:0]  OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0]  OP_WRITE_STATUS  = 8'h01;
    localparam logic [7:0]  OP_READ_STATUS   = 8'h05;
    localparam logic [7:0]  OP_READ_CONFIG   = 8'h35;
    localparam logic [7:0]  OP_READ_PARAM    = 8'h5A;
    localparam logic [7:0]  OP_QUAD_READ     = 8'hEB;
    localparam logic [3:0]  CONT_MODE_NIBBLE = 4'hA;
    localparam int          QE_BIT           = 1;
    localparam logic [7:0]  CONFIG_RESET     = 8'h00;
    // frame bit counts
    localparam logic [5:0]  CMD_BITS     = 6'd8;
    localparam logic [5:0]  ADDR_BITS    = 6'd24;
    localparam logic [5:0]  MODE_BITS    = 6'd8;
    localparam logic [5:0]  STATUS_BITS  = 6'd16;
    localparam int          PARAM_DUMMY_DEFAULT = 8;
    localparam int          QUAD_DUMMY_DEFAULT  = 4;
    // frame phases
    typedef enum logic [2:0] {
        PH_CMD, PH_ADDR, PH_MODE, PH_DUMMY, PH_DATA_IN, PH_DATA_OUT, PH_IDLE
    } link_phase_t;
    // persistent link state, also the crossing word
    typedef struct packed {
        logic quad;
        logic cont;
        logic qe;
        logic wel;
    } link_state_t;
    // offsets that hold a table byte
    function automatic logic param_hit(input logic [23:0] a);
        return (a >= OFS_QUAD_MODE_SWITCH && a <= OFS_WIDE_ADDR_ENTRY) ||
               (a >= OFS_MAP_HEADER && a <= OFS_MAP_REGION_COUNT);
    endfunction
    // fixed table bytes, reserved bits as ones
    function automatic logic [7:0] param_byte(input logic [23:0] a);
        case (a)
            OFS_QUAD_MODE_SWITCH: return VAL_QUAD_MODE_SWITCH;
            OFS_CONT_READ_EXIT:   return VAL_CONT_READ_EXIT;
            OFS_QUAD_ENABLE_LOC:  return VAL_QUAD_ENABLE_LOC;
            OFS_WORD15_RESERVED:  return VAL_WORD15_RESERVED;
            OFS_STATUS_WREN:      return VAL_STATUS_WREN;
            OFS_SOFT_RESET:       return VAL_SOFT_RESET;
            OFS_WIDE_ADDR_EXIT:   return VAL_WIDE_ADDR_EXIT;
            OFS_WIDE_ADDR_ENTRY:  return VAL_WIDE_ADDR_ENTRY;
            OFS_MAP_HEADER:       return VAL_MAP_HEADER;
            OFS_MAP_CONFIG_ID:    return VAL_MAP_CONFIG_ID;
            OFS_MAP_REGION_COUNT: return VAL_MAP_REGION_COUNT;
            default:              return VAL_UNUSED;
        endcase
    endfunction
endpackage
`default_nettype wire

/* File: hdl/flash_param_table.sv */
`default_nettype none
// How it works
// - FF or 66/99 leaves four-wire mode
// - 38h switches later transfers to four-wire, only while qe is set
// - mode byte Ax enters instruction-less read
// - other mode byte leaves instruction-less read
// - quad data pins only with config bit one
// - no control disables the hold function
// - status write refused without prior 06h
// - reset only on 66h then 99h
// - three-byte addresses, no wide address commands
// - map header marks map and last map
// - config id zero, count field five regions
// - reserved table bits read as ones
module flash_param_table #(
    parameter int PARAM_DUMMY = flash_param_pkg::PARAM_DUMMY_DEFAULT,
    parameter int QUAD_DUMMY  = flash_param_pkg::QUAD_DUMMY_DEFAULT
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic [3:0]  io_in,
    output var  logic [3:0]  io_out,
    output var  logic [3:0]  io_oe
);
    import flash_param_pkg::*;

    // dummy counts must fit the 6-bit clock counter
    if (PARAM_DUMMY < 1 || PARAM_DUMMY > 63 ||
        QUAD_DUMMY < 1 || QUAD_DUMMY > 63) begin : g_bad_dummy
        $error("dummy clock count out of range");
    end

    localparam logic [5:0] PARAM_DUMMY_CLKS = 6'(PARAM_DUMMY);
    localparam logic [5:0] QUAD_DUMMY_CLKS  = 6'(QUAD_DUMMY);

    // ---- pclk side declarations

    logic        control;      // link enable bit
    link_state_t st_meta;      // first sync stage
    link_state_t st_sync;      // link state seen on pclk
    logic        rtg_meta;     // reset toggle, first stage
    logic        rtg_sync;     // reset toggle, second stage
    logic        rtg_seen;     // last toggle level taken
    logic [7:0]  reset_count;  // soft resets seen
    logic [9:0]  idx;          // register index
    logic        apb_write;    // completing write

    // ---- sclk side declarations

    logic        frame_rst_n;  // clears frame state
    logic        len_meta;     // link enable, first stage
    logic        link_en;      // link enable on sclk
    link_state_t st;           // persistent link state
    logic        armed;        // 66h seen last
    logic        rst_tgl;      // flips per soft reset
    logic [5:0]  sr_prot;      // stored status bits
    logic [7:0]  config_reg;   // configuration register
    link_phase_t phase;        // frame phase
    logic [5:0]  cnt;          // bits or clocks in phase
    logic [23:0] sh;           // receive shift register
    logic [7:0]  cmd;          // current instruction
    logic        wide;         // four-wire after cmd
    logic [23:0] addr;         // read address
    logic [7:0]  osh;          // transmit shift register
    logic [2:0]  ocnt;         // beats left in byte

    // ---- combinational frame decode

    logic        wide_now;     // width of this edge
    logic [23:0] rx;           // shift value this edge
    logic [5:0]  cnt_next;     // bit count after edge
    logic        cont_start;   // frame opens in cont read
    logic        cmd_end;      // instruction complete
    logic [7:0]  opcode;       // instruction just taken
    logic        mode_end;     // mode byte complete
    logic        status_end;   // status write complete
    logic        dummy_end;    // last dummy clock
    logic        start_out;    // first output beat
    logic        reload;       // next output byte
    logic        out_w;        // output width
    logic [7:0]  src_cmd;      // command feeding output
    logic [7:0]  load_byte;    // byte to transmit
    logic [7:0]  status_byte;  // status register value
    logic [5:0]  dummy_clks;   // dummy length

    // ================= apb slave on pclk

    assign idx       = paddr[11:2];
    assign apb_write = psel && penable && pready && pwrite;

    // answer in the cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && !penable && !pready) begin
            pready <= 1'b1;
            if (pwrite) begin
                // only control takes writes
                pslverr <= (idx != IDX_CONTROL);
                prdata  <= 32'h0000_0000;
            end else if (idx == IDX_CONTROL) begin
                pslverr <= 1'b0;
                prdata  <= {31'h0000_0000, control};
            end else if (idx == IDX_STATUS) begin
                pslverr <= 1'b0;
                prdata  <= {16'h0000, reset_count, 4'h0, st_sync};
            end else if (param_hit({14'h0000, idx})) begin
                // fixed bytes, same on every read
                pslverr <= 1'b0;
                prdata  <= {24'h00_0000, param_byte({14'h0000, idx})};
            end else begin
                // unmapped index
                pslverr <= 1'b1;
                prdata  <= 32'h0000_0000;
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    // control register, write at access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control <= CONTROL_RESET;
        end else if (apb_write && idx == IDX_CONTROL) begin
            control <= pwdata[0];
        end
    end

    // link state levels into pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_meta <= '0;
            st_sync <= '0;
        end else begin
            st_meta <= st;
            st_sync <= st_meta;
        end
    end

    // soft reset event count via toggle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtg_meta    <= 1'b0;
            rtg_sync    <= 1'b0;
            rtg_seen    <= 1'b0;
            reset_count <= 8'h00;
        end else begin
            rtg_meta <= rst_tgl;
            rtg_sync <= rtg_meta;
            rtg_seen <= rtg_sync;
            if (rtg_sync != rtg_seen) begin
                reset_count <= reset_count + 8'h01;
            end
        end
    end

    // ================= link logic on sclk

    // deselect clears all frame state
    assign frame_rst_n = presetn & ~cs_n;

    // link enable level into sclk
    always_ff @(posedge sclk or negedge presetn) begin
        if (!presetn) begin
            len_meta <= 1'b0;
            link_en  <= 1'b0;
        end else begin
            len_meta <= control;
            link_en  <= len_meta;
        end
    end

    // status byte, busy never set here
    assign status_byte = {sr_prot, st.wel, 1'b0};

    // decode of the current edge
    always_comb begin
        // four-wire cmd only in quad or cont mode
        wide_now   = (phase == PH_CMD) ? (st.quad | st.cont) : wide;
        rx         = wide_now ? {sh[19:0], io_in} : {sh[22:0], io_in[0]};
        cnt_next   = cnt + (wide_now ? 6'd4 : 6'd1);
        // host has closed cont read before resets
        cont_start = (phase == PH_CMD) && (cnt == 6'd0) && st.cont && link_en;
        cmd_end    = (phase == PH_CMD) && !cont_start && link_en && (cnt_next == CMD_BITS);
        opcode     = rx[7:0];
        mode_end   = (phase == PH_MODE) && (cnt_next == MODE_BITS);
        status_end = (phase == PH_DATA_IN) && (cnt_next == STATUS_BITS);
        dummy_clks = (cmd == OP_QUAD_READ) ? QUAD_DUMMY_CLKS : PARAM_DUMMY_CLKS;
        dummy_end  = (phase == PH_DUMMY) && ((cnt + 6'd1) == dummy_clks);
        start_out  = dummy_end ||
                     (cmd_end && (opcode == OP_READ_STATUS || opcode == OP_READ_CONFIG));
        reload     = (phase == PH_DATA_OUT) && (ocnt == 3'd0);
        out_w      = (phase == PH_CMD) ? st.quad : wide;
        src_cmd    = (phase == PH_CMD) ? opcode : cmd;
        // array contents live outside; reads give erased value
        if (src_cmd == OP_READ_STATUS) begin
            load_byte = status_byte;
        end else if (src_cmd == OP_READ_CONFIG) begin
            load_byte = config_reg;
        end else if (src_cmd == OP_READ_PARAM) begin
            load_byte = param_byte(addr);
        end else begin
            load_byte = 8'hFF;
        end
    end

    // frame sequencing
    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            phase <= PH_CMD;
            cnt   <= 6'd0;
            sh    <= 24'h00_0000;
            cmd   <= 8'h00;
            wide  <= 1'b0;
            addr  <= 24'h00_0000;
        end else begin
            unique case (phase)
                PH_CMD: begin
                    sh  <= rx;
                    cnt <= cnt_next;
                    if (!link_en) begin
                        // disabled link ignores the frame
                        phase <= PH_IDLE;
                    end else if (cont_start) begin
                        // no instruction phase, first nibble is address
                        phase <= PH_ADDR;
                        cmd   <= OP_QUAD_READ;
                        wide  <= 1'b1;
                    end else if (cnt_next == CMD_BITS) begin
                        cnt  <= 6'd0;
                        cmd  <= opcode;
                        wide <= st.quad;
                        case (opcode)
                            OP_READ_PARAM: begin
                                phase <= PH_ADDR;
                            end
                            OP_QUAD_READ: begin
                                // quad read needs the quad pins
                                phase <= st.qe ? PH_ADDR : PH_IDLE;
                                wide  <= st.qe;
                            end
                            OP_WRITE_STATUS: begin
                                // data taken only after write enable
                                phase <= st.wel ? PH_DATA_IN : PH_IDLE;
                            end
                            OP_READ_STATUS, OP_READ_CONFIG: begin
                                phase <= PH_DATA_OUT;
                            end
                            default: begin
                                // no wide address entry or exit exists
                                phase <= PH_IDLE;
                            end
                        endcase
                    end
                end
                PH_ADDR: begin
                    sh  <= rx;
                    cnt <= cnt_next;
                    if (cnt_next == ADDR_BITS) begin
                        // three address bytes only
                        addr  <= rx;
                        cnt   <= 6'd0;
                        phase <= (cmd == OP_QUAD_READ) ? PH_MODE : PH_DUMMY;
                    end
                end
                PH_MODE: begin
                    sh  <= rx;
                    cnt <= cnt_next;
                    if (cnt_next == MODE_BITS) begin
                        cnt   <= 6'd0;
                        phase <= PH_DUMMY;
                    end
                end
                PH_DUMMY: begin
                    cnt <= cnt + 6'd1;
                    if (dummy_end) begin
                        phase <= PH_DATA_OUT;
                    end
                end
                PH_DATA_IN: begin
                    sh  <= rx;
                    cnt <= cnt_next;
                    if (status_end) begin
                        phase <= PH_IDLE;
                    end
                end
                PH_DATA_OUT: begin
                    // each new byte steps the address
                    if (reload) begin
                        addr <= addr + 24'h00_0001;
                    end
                end
                PH_IDLE: begin
                    // wait for deselect
                    cnt <= cnt;
                end
            endcase
            // first byte after dummy clocks also steps the address
            if (start_out) begin
                addr <= (phase == PH_CMD) ? addr : addr + 24'h00_0001;
            end
        end
    end

    // pin drive, changes after the rising edge
    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            io_out <= 4'h0;
            io_oe  <= 4'h0;
            osh    <= 8'h00;
            ocnt   <= 3'd0;
        end else if (start_out || reload) begin
            // load a byte, drive its first beat
            io_out <= out_w ? load_byte[7:4] : {2'b00, load_byte[7], 1'b0};
            osh    <= out_w ? {load_byte[3:0], 4'h0} : {load_byte[6:0], 1'b0};
            ocnt   <= out_w ? 3'd1 : 3'd7;
            // quad drive gated by the enable bit
            io_oe  <= out_w ? {4{config_reg[QE_BIT]}} : 4'b0010;
        end else if (phase == PH_DATA_OUT) begin
            // next beat of the byte
            io_out <= out_w ? osh[7:4] : {2'b00, osh[7], 1'b0};
            osh    <= out_w ? {osh[3:0], 4'h0} : {osh[6:0], 1'b0};
            ocnt   <= ocnt - 3'd1;
            // hold function has no disable control
            io_oe  <= out_w ? {4{config_reg[QE_BIT]}} : 4'b0010;
        end else begin
            io_out <= 4'h0;
            io_oe  <= 4'h0;
        end
    end

    // persistent state across frames
    always_ff @(posedge sclk or negedge presetn) begin
        if (!presetn) begin
            st         <= '0;
            armed      <= 1'b0;
            rst_tgl    <= 1'b0;
            sr_prot    <= 6'h00;
            config_reg <= CONFIG_RESET;
        end else begin
            st.qe <= status_end ? rx[QE_BIT] : config_reg[QE_BIT];
            if (cmd_end) begin
                // every instruction other than 66h drops the arm
                armed <= (opcode == OP_RESET_ENABLE);
                if (opcode == OP_QUAD_ENTER && st.qe) begin
                    st.quad <= 1'b1;
                end
                if (opcode == OP_QUAD_EXIT) begin
                    st.quad <= 1'b0;
                end
                if (opcode == OP_WRITE_ENABLE) begin
                    st.wel <= 1'b1;
                end
                if (opcode == OP_RESET && armed) begin
                    // soft reset back to single wire
                    st.quad <= 1'b0;
                    st.cont <= 1'b0;
                    st.wel  <= 1'b0;
                    rst_tgl <= ~rst_tgl;
                end
            end
            if (mode_end) begin
                // Ax keeps cont read, anything else leaves
                st.cont <= (rx[7:4] == CONT_MODE_NIBBLE);
            end
            if (status_end) begin
                // status byte then config byte
                sr_prot    <= rx[15:10];
                config_reg <= rx[7:0];
                st.wel     <= 1'b0;
            end
        end
    end

endmodule // flash_param_table
`default_nettype wire

/* File: test/flash_param_checker.sv */
`default_nettype none
// port-level watcher for the apb side and the pin enables
module flash_param_checker #(
    parameter int PARAM_DUMMY = 8, // dummy clocks of a table read
    parameter int QUAD_DUMMY  = 4  // dummy clocks of a quad read
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sclk,
    input wire logic        cs_n,
    input wire logic [3:0]  io_in,
    input wire logic [3:0]  io_out,
    input wire logic [3:0]  io_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // setup cycle still waiting for its answer
    sequence s_setup;
        psel && !penable && !pready;
    endsequence
    // a read of one table place answers with its fixed byte
    property p_table(a, v);
        s_setup ##0 (!pwrite && paddr == a) |=> prdata == v && !pslverr;
    endproperty
    chk_ready_zero_wait: assert property (s_setup |=> pready && penable)
        else $error("answer missing after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready held too long");
    chk_idle_outputs_zero: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
        else $error("read data or error outside access");
    chk_table_write_refused: assert property (
        s_setup ##0 (pwrite && paddr[11:2] != 10'h000) |=> pslverr) else $error("write not refused");
    chk_map_header_bits: assert property (p_table(12'h400, 32'h0000_00FF))
        else $error("map header wrong");
    chk_region_count_field: assert property (p_table(12'h408, 32'h0000_0004))
        else $error("region count wrong");
    chk_reserved_byte_ones: assert property (p_table(12'h1AC, 32'h0000_00FF))
        else $error("reserved byte wrong");
    chk_quad_switch_info: assert property (p_table(12'h1A0, 32'h0000_0029))
        else $error("mode switch byte wrong");
    chk_oe_legal_sets: assert property (io_oe inside {4'h0, 4'h2, 4'hF})
        else $error("illegal pin enable pattern");
    chk_oe_released: assert property (cs_n [*3] |-> io_oe == 4'h0)
        else $error("pins driven while deselected");
endmodule // flash_param_checker
bind flash_param_table flash_param_checker #(.PARAM_DUMMY(PARAM_DUMMY), .QUAD_DUMMY(QUAD_DUMMY)) i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
`default_nettype wire

/* File: test/flash_host_model.sv */
`default_nettype none
// serial host: clocks frames only while selected, mode 0
module flash_host_model (
    output var  logic       sclk,
    output var  logic       cs_n,
    output wire logic [3:0] io_in,
    input  wire logic [3:0] io_out,
    input  wire logic [3:0] io_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] host_val; // what the host puts on the lines
    // wire level: device wins where it drives
    assign io_in = (io_oe & io_out) | (~io_oe & host_val);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        host_val = 4'h5;
    end
    // send nb beats from tx (msb first), then take nrx beats back
    task automatic frame(input logic [63:0] tx, input int nb, input logic quad, input int nrx,
                         output logic [7:0] rx);
        rx = 8'h00;
        cs_n = 1'b0;
        for (int i = 0; i < nb + nrx; i++) begin
            // released lines toggle so stale values never pass
            host_val = (i < nb && quad) ? tx[63:60] : {~host_val[3:1], (i < nb) ? tx[63] : ~host_val[0]};
            tx = tx << (quad ? 4 : 1);
            #15;
            if (i >= nb)
                rx = quad ? {rx[3:0], io_in} : {rx[6:0], io_in[1]};
            sclk = 1'b1;
            #15 sclk = 1'b0;
        end
        #15 cs_n = 1'b1;
        host_val = ~host_val;
    endtask
endmodule // flash_host_model
`default_nettype wire

/* File: test/testbench.sv */
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin errors++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sclk, cs_n, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  io_in, io_out, io_oe;
    logic [7:0]  rx, cnt;
    int          errors, num_checks;
    // table places and their fixed bytes
    logic [11:0] tab_a [11] = '{12'h1A0, 12'h1A4, 12'h1A8, 12'h1AC, 12'h1B0, 12'h1B4, 12'h1B8, 12'h1BC,
                                12'h400, 12'h404, 12'h408};
    logic [7:0]  tab_v [11] = '{8'h29, 8'hC2, 8'h5C, 8'hFF, 8'hF0, 8'h30, 8'hC0, 8'h80, 8'hFF, 8'h00, 8'h04};
    flash_param_table #(.PARAM_DUMMY(8), .QUAD_DUMMY(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
    flash_host_model i_host (.sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // counts, verdict, end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one apb transfer, waits boundedly for pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 16) begin
            errors++;
            final_report();
        end
    endtask
    // one link frame, then let the status crossing settle
    task automatic link(input logic [63:0] tx, input int nb, input logic q, input int nrx);
        i_host.frame(tx, nb, q, nrx, rx);
        repeat (6) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0000_0000);
    endtask
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0000_0000;
        errors = 0; num_checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // every table byte, and a refused write to each
        for (int i = 0; i < 11; i++) begin
            apb(1'b0, tab_a[i], 32'h0000_0000);
            `CHK("table byte", {24'h000000, tab_v[i]}, rd);
            apb(1'b1, tab_a[i], 32'h0000_0000);
            `CHK("table write error", 1'b1, err);
        end
        apb(1'b0, 12'h1A0, 32'h0000_0000);
        `CHK("table after write", 32'h0000_0029, rd);
        apb(1'b0, 12'h800, 32'h0000_0000);
        `CHK("unmapped error", 1'b1, err);
        apb(1'b1, 12'h000, 32'h0000_0000);
        apb(1'b0, 12'h000, 32'h0000_0000);
        `CHK("control off", 32'h0000_0000, rd);
        apb(1'b1, 12'h000, 32'h0000_0001);
        link(64'h0, 8, 1'b0, 0);
        // wide address opcodes are ignored
        link({8'hB7, 56'h0}, 8, 1'b0, 0);
        link({8'h5A, 24'h000102, 32'h0}, 40, 1'b0, 8);
        `CHK("serial count", 8'h04, rx);
        link({8'h38, 56'h0}, 8, 1'b0, 0);
        `CHK("quad without qe", 1'b0, rd[3]);
        link({8'h01, 8'h00, 8'h02, 40'h0}, 24, 1'b0, 0);
        `CHK("write without wel", 1'b0, rd[1]);
        link({8'h06, 56'h0}, 8, 1'b0, 0);
        `CHK("wel set", 1'b1, rd[0]);
        link({8'h01, 8'h00, 8'h02, 40'h0}, 24, 1'b0, 0);
        `CHK("qe set wel clear", 2'b10, rd[1:0]);
        link({8'h38, 56'h0}, 8, 1'b0, 0);
        `CHK("quad entered", 1'b1, rd[3]);
        link({8'h5A, 24'h00006A, 32'h0}, 16, 1'b1, 2);
        `CHK("quad table byte", 8'h5C, rx);
        link({8'hEB, 24'h000000, 8'hA5, 24'h0}, 14, 1'b1, 2);
        `CHK("continuous on", 1'b1, rd[2]);
        link({24'h000000, 8'h3C, 32'h0}, 12, 1'b1, 2);
        `CHK("continuous off", 1'b0, rd[2]);
        link({8'hFF, 56'h0}, 2, 1'b1, 0);
        `CHK("quad left by exit", 1'b0, rd[3]);
        link({8'h38, 56'h0}, 8, 1'b0, 0);
        `CHK("quad on", 1'b1, rd[3]);
        cnt = rd[15:8];
        link({8'h66, 56'h0}, 2, 1'b1, 0);
        link({8'h99, 56'h0}, 2, 1'b1, 0);
        `CHK("quad left by reset", 1'b0, rd[3]);
        `CHK("reset counted", 8'(cnt + 8'h01), rd[15:8]);
        link({8'h99, 56'h0}, 8, 1'b0, 0);
        `CHK("lone reset ignored", 8'(cnt + 8'h01), rd[15:8]);
        final_report();
    end
endmodule // testbench
`default_nettype wire
